// [core/capcmp_timer_consts.vh]
/*
  Constants for the capture/compare timer channel: register byte
  offsets, field positions, mode codes and reset values.
  Assumes inclusion by bare name from the design files.
*/
`ifndef CAPCMP_TIMER_CONSTS_VH
`define CAPCMP_TIMER_CONSTS_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define OFS_MODE_CTRL     12'h000
`define OFS_OUT_CTRL      12'h004
`define OFS_CAPCMP_CTRL   12'h008
`define OFS_COUNT         12'h00c
`define OFS_MATCH_FIRST   12'h010
`define OFS_MATCH_SECOND  12'h014

// ----------------------------------------------------------------
// Mode control fields
// ----------------------------------------------------------------
`define MODE_LO_BIT       2
`define MODE_HI_BIT       3
`define WRAP_FLAG_BIT     0
`define MODE_STOP         2'b00
`define MODE_FREE         2'b01
`define MODE_EDGE_CLEAR   2'b10
`define MODE_PULSE_GEN    2'b11

// ----------------------------------------------------------------
// Output control fields
// ----------------------------------------------------------------
`define OUT_ENABLE_BIT    0
`define SP_ENABLE_BIT     5
`define SP_TRIGGER_BIT    6

// ----------------------------------------------------------------
// Capture/compare control fields
// ----------------------------------------------------------------
`define FIRST_IS_CAPTURE  0
`define FIRST_SRC_OPP     1
`define SECOND_IS_CAPTURE 2

// ----------------------------------------------------------------
// Edge select fields (bits 5:4 first input, 7:6 second input)
// 00 falling, 01 rising, 10/11 both
// ----------------------------------------------------------------
`define EDGE_SEL_FIRST_LO  4
`define EDGE_SEL_SECOND_LO 6

`define COUNT_RESET       16'h0000
`define COUNT_ALL_ONES    16'hffff

`endif

// [core/edge_detect.v]
/*
  Two-flop synchroniser with rising/falling edge detection for one
  input pin. Assumes the pin is asynchronous to CLK.
*/
`timescale 1ns/1ps
`default_nettype none

module edge_detect (
  // Clock and reset
  input  wire CLK,
  input  wire SYS_RST,
  // Pin and edges
  input  wire pin,
  output reg  rise,
  output reg  fall
);

  reg sync_a;
  reg sync_b;
  reg last;

  // --------------------------------------------------------------
  // Synchroniser; only sync_b is looked at by logic
  // --------------------------------------------------------------
  always @(posedge CLK) begin
    if (SYS_RST) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
      last   <= 1'b0;
      rise   <= 1'b0;
      fall   <= 1'b0;
    end else begin
      sync_a <= pin;
      sync_b <= sync_a;
      last   <= sync_b;
      rise   <= sync_b & ~last;
      fall   <= ~sync_b & last;
    end
  end

endmodule // edge_detect

`default_nettype wire

// [core/capcmp_timer.v]
/*
  16-bit timer channel with two capture/compare registers, one-shot
  pulse output and pulse-width capture, reached over APB.
  Assumes an APB master on CLK and asynchronous input pins.
*/
`timescale 1ns/1ps
`default_nettype none
`include "capcmp_timer_consts.vh"

module capcmp_timer (
  // Clock and reset
  input  wire        CLK,
  input  wire        SYS_RST,
  // APB slave
  input  wire        PSEL,
  input  wire        PENABLE,
  input  wire        PWRITE,
  input  wire [11:0] PADDR,
  input  wire [31:0] PWDATA,
  output reg  [31:0] PRDATA,
  output reg         PREADY,
  output reg         PSLVERR,
  // Trigger and capture pins
  input  wire        TRIGGER_INPUT_FIRST,
  input  wire        TRIGGER_INPUT_SECOND,
  // Wave output and match events
  output reg         WAVE_OUTPUT_PIN,
  output reg         MATCH_IRQ_FIRST,
  output reg         MATCH_IRQ_SECOND
);

  // --------------------------------------------------------------
  // State
  // --------------------------------------------------------------
  reg  [7:0]  mode_control_reg;
  reg  [7:0]  output_control_reg;
  reg  [7:0]  capcmp_control_reg;
  reg  [15:0] count_value_reg;
  reg  [15:0] match_capture_first;
  reg  [15:0] match_capture_second;
  reg         wrap_flag;
  reg         wrap_pending;
  reg         pulse_busy;
  reg         sw_trigger;

  // Bus strobes; a write lands at the access edge, a read is taken at setup
  wire        bus_wr = PSEL & PENABLE & PWRITE;
  wire        bus_rd = PSEL & ~PENABLE & ~PWRITE;

  wire        first_rise;
  wire        first_fall;
  wire        second_rise;
  wire        second_fall;

  wire [1:0]  op_mode = {mode_control_reg[`MODE_HI_BIT], mode_control_reg[`MODE_LO_BIT]};
  wire        running = (op_mode != `MODE_STOP);
  wire        single_pulse_enable = output_control_reg[`SP_ENABLE_BIT];
  wire        out_enable = output_control_reg[`OUT_ENABLE_BIT];
  wire        first_is_capture = capcmp_control_reg[`FIRST_IS_CAPTURE];
  wire        first_src_opp = capcmp_control_reg[`FIRST_SRC_OPP];
  wire        second_is_capture = capcmp_control_reg[`SECOND_IS_CAPTURE];

  // --------------------------------------------------------------
  // Pin synchronisers and edge detectors
  // --------------------------------------------------------------
  edge_detect u_first (
    .CLK     (CLK),
    .SYS_RST (SYS_RST),
    .pin     (TRIGGER_INPUT_FIRST),
    .rise    (first_rise),
    .fall    (first_fall)
  );

  edge_detect u_second (
    .CLK     (CLK),
    .SYS_RST (SYS_RST),
    .pin     (TRIGGER_INPUT_SECOND),
    .rise    (second_rise),
    .fall    (second_fall)
  );

  // Edges reach the logic three clocks after the pin moves
  // Valid-edge selection: 00 falling, 01 rising, 1x both
  function edge_valid;
    input [1:0] sel;
    input       r;
    input       f;
    begin
      case (sel)
        2'b00:   edge_valid = f;
        2'b01:   edge_valid = r;
        default: edge_valid = r | f;
      endcase
    end
  endfunction

  // Opposite edge to the selected one; none when both are selected
  function edge_opposite;
    input [1:0] sel;
    input       r;
    input       f;
    begin
      case (sel)
        2'b00:   edge_opposite = r;
        2'b01:   edge_opposite = f;
        default: edge_opposite = 1'b0;
      endcase
    end
  endfunction

  wire [1:0] sel_first  = capcmp_control_reg[`EDGE_SEL_FIRST_LO+1:`EDGE_SEL_FIRST_LO];
  wire [1:0] sel_second = capcmp_control_reg[`EDGE_SEL_SECOND_LO+1:`EDGE_SEL_SECOND_LO];
  wire first_valid  = running & edge_valid(sel_first, first_rise, first_fall);
  wire first_opp    = running & edge_opposite(sel_first, first_rise, first_fall);
  wire second_valid = running & edge_valid(sel_second, second_rise, second_fall);

  // --------------------------------------------------------------
  // Event decode
  // --------------------------------------------------------------
  // One-shot is allowed only in free-running or edge-clear mode
  wire sp_allowed = single_pulse_enable &
                    ((op_mode == `MODE_FREE) | (op_mode == `MODE_EDGE_CLEAR));
  // Retrigger during a pulse starts no new pulse, but in edge-clear mode a first-input edge still clears the counter; software must not do it anyway
  wire sp_start = sp_allowed & ~pulse_busy & (sw_trigger | first_valid);

  wire match_first  = running & ~first_is_capture &
                      (count_value_reg == match_capture_first);
  wire match_second = running & ~second_is_capture &
                      (count_value_reg == match_capture_second);

  // First capture source: second input edge, or opposite first edge
  wire cap_first = running & first_is_capture &
                   (first_src_opp ? first_opp : second_valid);
  // Second capture only ever comes from the first input
  wire cap_second = running & second_is_capture & first_valid;

  wire edge_clear = (op_mode == `MODE_EDGE_CLEAR) & first_valid;
  wire ppg_clear  = (op_mode == `MODE_PULSE_GEN) & match_first;

  // --------------------------------------------------------------
  // Counter and wrap flag
  // --------------------------------------------------------------
  // Mode 00 holds zero; one-shot start, edge clear and pulse-gen clear take priority over counting
  always @(posedge CLK) begin
    if (SYS_RST) begin
      count_value_reg <= `COUNT_RESET;
      wrap_pending    <= 1'b0;
    end else if (!running) begin
      count_value_reg <= `COUNT_RESET;
      wrap_pending    <= 1'b0;
    end else if (sp_start | edge_clear | ppg_clear) begin
      count_value_reg <= `COUNT_RESET;
      wrap_pending    <= 1'b0;
    end else begin
      count_value_reg <= count_value_reg + 16'h0001;
      wrap_pending    <= (count_value_reg == `COUNT_ALL_ONES);
    end
  end

  // --------------------------------------------------------------
  // Capture registers and interrupts
  // --------------------------------------------------------------
  // Hardware capture wins over a same-cycle software write
  always @(posedge CLK) begin
    if (SYS_RST) begin
      match_capture_first  <= 16'h0000;
      match_capture_second <= 16'h0000;
    end else begin
      if (cap_first)
        match_capture_first <= count_value_reg;
      else if (bus_wr && PADDR == `OFS_MATCH_FIRST)
        match_capture_first <= PWDATA[15:0];
      if (cap_second)
        match_capture_second <= count_value_reg;
      else if (bus_wr && PADDR == `OFS_MATCH_SECOND)
        match_capture_second <= PWDATA[15:0];
    end
  end

  // Interrupt pulses for both matches and captures, one cycle wide
  always @(posedge CLK) begin
    if (SYS_RST) begin
      MATCH_IRQ_FIRST  <= 1'b0;
      MATCH_IRQ_SECOND <= 1'b0;
    end else begin
      MATCH_IRQ_FIRST  <= match_first | cap_first;
      MATCH_IRQ_SECOND <= match_second | cap_second;
    end
  end

  // --------------------------------------------------------------
  // Wave output and one-shot state
  // --------------------------------------------------------------
  // Output toggles when exactly one compare matches; one-shot ends on match_first
  always @(posedge CLK) begin
    if (SYS_RST) begin
      WAVE_OUTPUT_PIN <= 1'b0;
      pulse_busy      <= 1'b0;
    end else if (!running) begin
      pulse_busy      <= 1'b0;
    end else begin
      if (sp_allowed) begin
        if (sp_start)
          pulse_busy <= 1'b1;
        else if (pulse_busy && match_first)
          pulse_busy <= 1'b0;
        if (pulse_busy && out_enable && (match_first ^ match_second))
          WAVE_OUTPUT_PIN <= ~WAVE_OUTPUT_PIN;
      end else if (out_enable && (match_first ^ match_second)) begin
        WAVE_OUTPUT_PIN <= ~WAVE_OUTPUT_PIN;
      end
    end
  end

  // --------------------------------------------------------------
  // APB slave, zero wait states
  // --------------------------------------------------------------
  // PRDATA is a snapshot taken at the setup edge, so a count read lags
  // the live counter by one clock; software must allow for that

  function addr_mapped;
    input [11:0] a;
    begin
      addr_mapped = (a == `OFS_MODE_CTRL)   | (a == `OFS_OUT_CTRL) |
                    (a == `OFS_CAPCMP_CTRL) | (a == `OFS_COUNT) |
                    (a == `OFS_MATCH_FIRST) | (a == `OFS_MATCH_SECOND);
    end
  endfunction

  // Control writes; trigger bit self-clears, wrap flag set wins
  always @(posedge CLK) begin
    if (SYS_RST) begin
      mode_control_reg   <= 8'h00;
      output_control_reg <= 8'h00;
      capcmp_control_reg <= 8'h00;
      wrap_flag          <= 1'b0;
      sw_trigger         <= 1'b0;
    end else begin
      sw_trigger <= bus_wr && PADDR == `OFS_OUT_CTRL && PWDATA[`SP_TRIGGER_BIT];
      if (bus_wr && PADDR == `OFS_MODE_CTRL)
        mode_control_reg <= {PWDATA[7:1], 1'b0};
      if (bus_wr && PADDR == `OFS_OUT_CTRL)
        output_control_reg <= {1'b0, PWDATA[6:0]} & 8'hbf;
      if (bus_wr && PADDR == `OFS_CAPCMP_CTRL)
        capcmp_control_reg <= PWDATA[7:0];
      if (wrap_pending)
        wrap_flag <= 1'b1;
      else if (bus_wr && PADDR == `OFS_MODE_CTRL && !PWDATA[`WRAP_FLAG_BIT])
        wrap_flag <= 1'b0;
    end
  end

  // Read data latched in setup phase, ready in access phase
  always @(posedge CLK) begin
    if (SYS_RST) begin
      PRDATA  <= 32'h0000_0000;
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
    end else begin
      PREADY  <= PSEL & ~PENABLE;
      PSLVERR <= PSEL & ~PENABLE & ~addr_mapped(PADDR);
      if (bus_rd) begin
        case (PADDR)
          `OFS_MODE_CTRL:    PRDATA <= {24'h0, mode_control_reg[7:1], wrap_flag};
          `OFS_OUT_CTRL:     PRDATA <= {24'h0, output_control_reg};
          `OFS_CAPCMP_CTRL:  PRDATA <= {24'h0, capcmp_control_reg};
          `OFS_COUNT:        PRDATA <= {16'h0, count_value_reg};
          `OFS_MATCH_FIRST:  PRDATA <= {16'h0, match_capture_first};
          `OFS_MATCH_SECOND: PRDATA <= {16'h0, match_capture_second};
          default:           PRDATA <= 32'h0000_0000;
        endcase
      end
    end
  end

endmodule // capcmp_timer

`default_nettype wire

// [verif/capcmp_timer_assertions.sv]
/*
  Port-level checks for the timer channel, bound into the design.
  Assumes an APB master that keeps the setup/access order.
*/
`timescale 1ns/1ps
`default_nettype none
`include "capcmp_timer_consts.vh"

module capcmp_timer_assertions (
  // Clock and reset
  input wire logic        CLK,
  input wire logic        SYS_RST,
  // APB
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic        PREADY,
  input wire logic        PSLVERR,
  // Pins and events
  input wire logic        TRIGGER_INPUT_FIRST,
  input wire logic        TRIGGER_INPUT_SECOND,
  input wire logic        WAVE_OUTPUT_PIN,
  input wire logic        MATCH_IRQ_FIRST,
  input wire logic        MATCH_IRQ_SECOND
);
  logic [1:0] mode;

  // Shadow of the mode field; the quiet checks need to know when stopped
  always @(posedge CLK)
    if (SYS_RST)
      mode <= 2'b00;
    else if (PSEL && PENABLE && PWRITE && PREADY && PADDR == `OFS_MODE_CTRL)
      mode <= PWDATA[`MODE_HI_BIT:`MODE_LO_BIT];

  default clocking @(posedge CLK); endclocking
  default disable iff (SYS_RST);

  // --------------------
  // Assertions
  // --------------------
  pready_one_a: assert property (PSEL && !PENABLE |=> PREADY)
    else $error("no ready one cycle after setup");
  pready_pulse_a: assert property (PREADY |=> !PREADY)
    else $error("ready held past one cycle");
  err_ready_a: assert property (PSLVERR |-> PREADY)
    else $error("error without ready");
  unmapped_err_a: assert property (PSEL && !PENABLE && PADDR > `OFS_MATCH_SECOND |=> PSLVERR)
    else $error("unmapped access not refused");
  mapped_ok_a: assert property (PSEL && !PENABLE && PADDR <= `OFS_MATCH_SECOND
                                && PADDR[1:0] == 2'b00 |=> !PSLVERR)
    else $error("mapped access refused");
  stop_quiet_a: assert property ((mode == 2'b00)[*4] |->
      !MATCH_IRQ_FIRST && !MATCH_IRQ_SECOND && $stable(WAVE_OUTPUT_PIN))
    else $error("event while stopped");
  stop_count_a: assert property ((mode == 2'b00)[*3] ##1
      (PREADY && !PWRITE && PADDR == `OFS_COUNT) |-> PRDATA == 32'h0)
    else $error("count not zero while stopped");
  wave_irq_a: assert property ($changed(WAVE_OUTPUT_PIN) |->
      MATCH_IRQ_FIRST || MATCH_IRQ_SECOND)
    else $error("output flipped without match");
  rdata_hold_a: assert property ($changed(PRDATA) |-> PREADY && !PWRITE)
    else $error("read data moved outside a read");

  // Main scenarios reached
  cover property (MATCH_IRQ_FIRST && mode == `MODE_PULSE_GEN);
  cover property ($rose(WAVE_OUTPUT_PIN));
  cover property (PSLVERR);
endmodule // capcmp_timer_assertions

bind capcmp_timer capcmp_timer_assertions capcmp_timer_assertions_i (
  .CLK(CLK), .SYS_RST(SYS_RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
  .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
  .TRIGGER_INPUT_FIRST(TRIGGER_INPUT_FIRST), .TRIGGER_INPUT_SECOND(TRIGGER_INPUT_SECOND),
  .WAVE_OUTPUT_PIN(WAVE_OUTPUT_PIN), .MATCH_IRQ_FIRST(MATCH_IRQ_FIRST),
  .MATCH_IRQ_SECOND(MATCH_IRQ_SECOND));
`default_nettype wire

// [verif/pin_source.sv]
/*
  Far-side model: drives both trigger pins and times the wave output.
  Assumes the bench calls toggle right after a clock edge.
*/
`timescale 1ns/1ps
`default_nettype none

module pin_source (
  // Clock and observed output
  input  wire logic        CLK,
  input  wire logic        wave,
  // Driven pins and high-time count
  output var  logic        first_pin,
  output var  logic        second_pin,
  output var  logic [31:0] high_len
);
  // Pins idle low; bench edge selects assume this start
  initial begin
    first_pin  = 1'b0;
    second_pin = 1'b0;
    high_len   = 32'h0000_0000;
  end

  // Clocks with the output high, for pulse widths
  always @(posedge CLK)
    if (wave === 1'b1)
      high_len <= high_len + 32'h0000_0001;

  // Flip one pin after an edge, then hold it; waits out a running pulse
  task automatic toggle(input logic sec, input int hold);
    for (int i = 0; i < 500 && wave === 1'b1; i++)
      @(posedge CLK);
    @(posedge CLK);
    if (sec)
      second_pin <= ~second_pin;
    else
      first_pin <= ~first_pin;
    repeat (hold) @(posedge CLK);
  endtask
endmodule // pin_source
`default_nettype wire

// [verif/timer_oneshot_pulse_measure_tb_top.sv]
/*
  Self-checking bench for the timer channel: APB tasks, pin model,
  seeded random gaps and compare values. Assumes header on include path.
*/
`timescale 1ns/1ps
`default_nettype none
`include "capcmp_timer_consts.vh"

module timer_oneshot_pulse_measure_tb_top;
  logic        CLK, SYS_RST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, rerr;
  logic [11:0] PADDR;
  logic [31:0] PWDATA, PRDATA, rdata, high_len;
  logic        TRIGGER_INPUT_FIRST, TRIGGER_INPUT_SECOND;
  logic        WAVE_OUTPUT_PIN, MATCH_IRQ_FIRST, MATCH_IRQ_SECOND;
  int          bad_count, tests_run, seed;

  capcmp_timer capcmp_timer_i (.CLK(CLK), .SYS_RST(SYS_RST), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .TRIGGER_INPUT_FIRST(TRIGGER_INPUT_FIRST),
    .TRIGGER_INPUT_SECOND(TRIGGER_INPUT_SECOND), .WAVE_OUTPUT_PIN(WAVE_OUTPUT_PIN),
    .MATCH_IRQ_FIRST(MATCH_IRQ_FIRST), .MATCH_IRQ_SECOND(MATCH_IRQ_SECOND));
  pin_source pin_source_i (.CLK(CLK), .wave(WAVE_OUTPUT_PIN),
    .first_pin(TRIGGER_INPUT_FIRST), .second_pin(TRIGGER_INPUT_SECOND), .high_len(high_len));

  // 100 MHz clock
  initial begin
    CLK = 1'b0;
    forever #5 CLK = ~CLK;
  end

  // --------------------
  // Tasks
  // --------------------
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // One APB transfer; no wait-state count assumed, bounded wait for ready
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge CLK);
    PSEL   <= 1'b1;
    PWRITE <= w;
    PADDR  <= a;
    PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1'b1;
    do begin
      @(posedge CLK);
      n++;
    end while (PREADY !== 1'b1 && n < 50);
    rdata = PRDATA;
    rerr  = PSLVERR;
    PSEL    <= 1'b0;
    PENABLE <= 1'b0;
    if (n >= 50) begin
      bad_count++;
      print_verdict;
    end
  endtask

  // Clocks until the chosen match event is seen
  task automatic wait_irq(input logic sec, output int n);
    n = 0;
    do begin
      @(posedge CLK);
      n++;
    end while ((sec ? MATCH_IRQ_SECOND : MATCH_IRQ_FIRST) !== 1'b1 && n < 1000);
    if (n >= 1000) begin
      bad_count++;
      print_verdict;
    end
  endtask

  task automatic set_cmp(input logic [31:0] f, input logic [31:0] s);
    apb(1'b1, `OFS_MATCH_FIRST, f);
    apb(1'b1, `OFS_MATCH_SECOND, s);
  endtask

  // --------------------
  // Main sequence
  // --------------------
  initial begin
    int h1, h2, h3, n;
    logic [31:0] f, s, c1, c2;
    seed      = 32'ha9c43d99;
    bad_count = 0;
    tests_run = 0;
    SYS_RST   = 1'b1;
    PSEL      = 1'b0;
    PENABLE   = 1'b0;
    PWRITE    = 1'b0;
    PADDR     = 12'h000;
    PWDATA    = 32'h0000_0000;
    repeat (2) @(posedge CLK);
    SYS_RST <= 1'b0;
    apb(1'b0, `OFS_COUNT, 32'h0);
    chk("count_rst", 32'h0, rdata);
    apb(1'b0, 12'h020, 32'h0);
    chk("unmapped_err", 32'h1, {31'h0, rerr});
    chk("unmapped_rd", 32'h0, rdata);
    f = 32'h40 + ($random(seed) & 32'h3f);
    s = 32'h04 + ($random(seed) & 32'h1f);
    set_cmp(f, s);
    apb(1'b0, `OFS_MATCH_FIRST, 32'h0);
    chk("first_cmp", f, rdata);
    $display("register test done");
    // One-shot: soft trigger and pin trigger in mode 01, pin in mode 10
    apb(1'b1, `OFS_CAPCMP_CTRL, 32'h10);
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, `OFS_OUT_CTRL, 32'h21);
      apb(1'b1, `OFS_MODE_CTRL, i == 2 ? 32'h8 : 32'h4);
      c1 = high_len;
      if (i == 0)
        apb(1'b1, `OFS_OUT_CTRL, 32'h61);
      else
        pin_source_i.toggle(1'b0, 0);
      repeat (160) @(posedge CLK);
      chk("pulse_width", f - s, high_len - c1);
      chk("pulse_end", 32'h0, {31'h0, WAVE_OUTPUT_PIN});
      apb(1'b1, `OFS_MODE_CTRL, 32'h0);
      if (i > 0)
        pin_source_i.toggle(1'b0, 4);
    end
    apb(1'b1, `OFS_OUT_CTRL, 32'h0);
    $display("one-shot test done");
    // Two inputs, both edges: gap between pins lands in the captures
    apb(1'b1, `OFS_CAPCMP_CTRL, 32'ha5);
    apb(1'b1, `OFS_MODE_CTRL, 32'h4);
    h1 = 5 + ($random(seed) & 63);
    pin_source_i.toggle(1'b0, h1);
    pin_source_i.toggle(1'b1, 8);
    apb(1'b0, `OFS_MATCH_FIRST, 32'h0);
    c1 = rdata;
    apb(1'b0, `OFS_MATCH_SECOND, 32'h0);
    c2 = rdata;
    chk("two_pin_gap", 32'(h1 + 1), c1 - c2);
    // Edges while stopped must leave both captures alone
    apb(1'b1, `OFS_MODE_CTRL, 32'h0);
    pin_source_i.toggle(1'b1, 4);
    pin_source_i.toggle(1'b0, 8);
    apb(1'b0, `OFS_MATCH_FIRST, 32'h0);
    chk("stop_first", c1, rdata);
    apb(1'b0, `OFS_MATCH_SECOND, 32'h0);
    chk("stop_second", c2, rdata);
    apb(1'b0, `OFS_COUNT, 32'h0);
    chk("stop_count", 32'h0, rdata);
    // One input, rising valid: the falling edge feeds the first register
    apb(1'b1, `OFS_CAPCMP_CTRL, 32'h17);
    apb(1'b1, `OFS_MODE_CTRL, 32'h4);
    h2 = 5 + ($random(seed) & 63);
    pin_source_i.toggle(1'b0, h2);
    pin_source_i.toggle(1'b0, 8);
    apb(1'b0, `OFS_MATCH_FIRST, 32'h0);
    c1 = rdata;
    apb(1'b0, `OFS_MATCH_SECOND, 32'h0);
    chk("one_pin_width", 32'(h2 + 1), c1 - rdata);
    // Mode 10, falling valid: each fall clears, so captures are absolute
    apb(1'b1, `OFS_MODE_CTRL, 32'h0);
    apb(1'b1, `OFS_CAPCMP_CTRL, 32'h07);
    apb(1'b1, `OFS_MODE_CTRL, 32'h8);
    h3 = 2 + ($random(seed) & 3);
    pin_source_i.toggle(1'b0, h1);
    pin_source_i.toggle(1'b0, h2);
    pin_source_i.toggle(1'b0, h3);
    pin_source_i.toggle(1'b0, 8);
    apb(1'b0, `OFS_MATCH_FIRST, 32'h0);
    c1 = rdata;
    apb(1'b0, `OFS_MATCH_SECOND, 32'h0);
    chk("clear_open", 32'(h2), c1);
    chk("clear_start", 32'(h2 + h3 + 1), rdata);
    $display("capture test done");
    // Pulse generation: match spacing gives second offset and second-to-first gap
    apb(1'b1, `OFS_MODE_CTRL, 32'h0);
    apb(1'b1, `OFS_CAPCMP_CTRL, 32'h0);
    set_cmp(f, s);
    apb(1'b1, `OFS_MODE_CTRL, 32'hc);
    wait_irq(1'b0, n);
    wait_irq(1'b1, n);
    chk("second_match", s + 32'h1, 32'(n));
    wait_irq(1'b0, n);
    chk("first_match", f - s, 32'(n));
    $display("pulse gen test done");
    // Free run: count reads track time, then wrap flag after roll-over
    apb(1'b1, `OFS_MODE_CTRL, 32'h0);
    apb(1'b1, `OFS_MODE_CTRL, 32'h4);
    apb(1'b0, `OFS_COUNT, 32'h0);
    c1 = rdata;
    apb(1'b0, `OFS_COUNT, 32'h0);
    chk("count_step", 32'h3, rdata - c1);
    repeat (65536) @(posedge CLK);
    apb(1'b0, `OFS_MODE_CTRL, 32'h0);
    chk("wrap_set", 32'h5, rdata);
    apb(1'b1, `OFS_MODE_CTRL, 32'h4);
    apb(1'b0, `OFS_MODE_CTRL, 32'h0);
    chk("wrap_clear", 32'h4, rdata);
    $display("wrap test done");
    print_verdict;
  end
endmodule // timer_oneshot_pulse_measure_tb_top
`default_nettype wire
